// *** rtl/uafc_ctrl.sv ***
// uafc_ctrl: alternate-function register and its effects for one channel.
// assumes host bus strobes are synchronous single-cycle pulses on clock_i;
// the serial input pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
// Operation
// RL1 - register answers at address 2 only when line control upper bits are 100
// RL2 - concurrent write enable copies every host write to all channels
// RL3 - host enables indirect addressing before setting concurrent write
// RL4 - bit 1 selects infrared mode; host keeps rate at or below 115.2k
// RL5 - half-duplex mode drives driver-enable high while transmit data pending
// RL6 - driver-enable stays high until turnaround delay expires, then low
// RL7 - half-duplex without large-block holds transmit interrupt until shifter empty
// RL8 - large-block mode gives normal transmit interrupts
// RL9 - snoop enable counts only in half-duplex or infrared mode; the timeout interrupt gate uses the raw snoop bit in every mode
// RL10 - half-duplex with snoop receives everything, even while transmitting
// RL11 - without half-duplex or infrared the receiver stays enabled
// RL12 - half-duplex without snoop disables receiver while transmitting
// RL13 - infrared without snoop drops own echo
// RL14 - snoop clear blocks the character timeout interrupt
// RL15 - delay bits 7:5 in bit times, start when empty, cancel on write
// RL16 - reset clears all alternate function bits
module uafc_ctrl #(
    parameter int CHANNELS = uafc_pkg::CHANNELS,
    parameter int BIT_DIV  = uafc_pkg::BIT_TIME_DIV_DEF
) (
    // clock and reset
    input  wire logic                clock_i,
    input  wire logic                reset_n_i,
    // host register port
    input  wire logic [2:0]          addr_i,
    input  wire logic [7:0]          wdata_i,
    input  wire logic                write_i,
    input  wire logic                read_i,
    input  wire logic [7:0]          line_control_register_i,
    output logic [7:0]               rdata_o,
    output logic                     sel_o,
    output logic [CHANNELS-1:0]      channel_write_o,
    input  wire logic [CHANNELS-1:0] channel_select_i,
    // transmitter state of this channel
    input  wire logic                tx_fifo_empty_i,
    input  wire logic                tx_shift_empty_i,
    input  wire logic                tx_fifo_below_thr_i,
    input  wire logic                tx_write_i,
    input  wire logic                bit_tick_i,
    // receiver state of this channel
    input  wire logic                serial_in_i,
    input  wire logic                char_timeout_i,
    // outputs
    output logic                     serial_in_o,
    output logic                     rx_enable_o,
    output logic                     tx_irq_o,
    output logic                     timeout_irq_o,
    output logic                     bus_driver_enable_output_o,
    output logic                     infrared_mode_enable_o,
    output logic                     concurrent_write_enable_o
);
    logic [7:0]       alternate_function_register_q;
    logic [7:0]       alternate_function_register_d;
    logic [2:0]       rx_sync_q;
    logic             rx_level_q;
    logic             tx_irq_q;
    logic             timeout_irq_q;
    logic             rx_enable_q;
    logic [7:0]       rdata_q;

    wire              afr_sel_w;
    wire              afr_wr_w;
    wire              concurrent_write_enable_w;
    wire              ir_w;
    wire              hdx_w;
    wire              large_w;
    wire              snoop_raw_w;
    wire              snoop_w;
    wire              tx_busy_w;
    wire              transmitting_w;
    wire              rx_en_w;
    wire              tx_irq_w;
    wire [2:0]        dly_w;

    function automatic logic afr_hit(input logic [2:0] a, input logic [7:0] line_control_register);
        afr_hit = (a == uafc_pkg::ALT_FUNC_ADDR) && (line_control_register[7:5] == uafc_pkg::LINE_CTRL_PAGE);
    endfunction : afr_hit

    assign afr_sel_w   = afr_hit(addr_i, line_control_register_i); // [RL1]
    assign afr_wr_w    = write_i && afr_sel_w;
    assign sel_o       = afr_sel_w;

    assign concurrent_write_enable_w      = alternate_function_register_q[uafc_pkg::CONCURRENT_WRITE_ENABLE_BIT];
    assign ir_w        = alternate_function_register_q[uafc_pkg::IR_BIT];
    assign hdx_w       = alternate_function_register_q[uafc_pkg::HDX_BIT];
    assign large_w     = alternate_function_register_q[uafc_pkg::LARGE_BIT];
    assign snoop_raw_w = alternate_function_register_q[uafc_pkg::SNOOP_BIT];
    assign dly_w       = alternate_function_register_q[uafc_pkg::DLY_LSB +: uafc_pkg::DLY_W];

    // snoop counts only in half-duplex or infrared mode
    assign snoop_w     = snoop_raw_w && (hdx_w || ir_w); // [RL9]

    // fan host write out to channels
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chwr
            assign channel_write_o[g] = write_i && (concurrent_write_enable_w || channel_select_i[g]); // [RL2]
        end
    endgenerate

    assign alternate_function_register_d = afr_wr_w ? wdata_i : alternate_function_register_q;

    assign tx_busy_w      = !tx_fifo_empty_i || !tx_shift_empty_i;
    assign transmitting_w = tx_busy_w || bus_driver_enable_output_o;

    // receiver gating
    assign rx_en_w = !hdx_w ? (!ir_w || snoop_w || !tx_busy_w)    // [RL11] [RL13]
                            : (snoop_w || !transmitting_w);        // [RL10] [RL12]

    // transmit interrupt source
    assign tx_irq_w = (hdx_w && !large_w) ? (tx_shift_empty_i && tx_fifo_empty_i) // [RL7]
                                          : (tx_fifo_below_thr_i || tx_fifo_empty_i); // [RL8]

    uafc_turnaround #(
        .DLY_W (uafc_pkg::DLY_W)
    ) u_turn (
        .clock_i         (clock_i),
        .reset_n_i       (reset_n_i),
        .enable_i        (hdx_w),
        .delay_i         (dly_w),
        .bit_tick_i      (bit_tick_i),
        .tx_busy_i       (tx_busy_w),
        .tx_write_i      (tx_write_i),
        .driver_enable_o (bus_driver_enable_output_o)
    );

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alternate_function_register_q <= uafc_pkg::ALT_FUNC_RESET; // [RL16]
            rx_sync_q                     <= 3'h7;
            rx_level_q                    <= 1'b1;
            tx_irq_q                      <= 1'b0;
            timeout_irq_q                 <= 1'b0;
            rx_enable_q                   <= 1'b1;
            rdata_q                       <= 8'h00;
        end else begin
            alternate_function_register_q <= alternate_function_register_d;
            rx_sync_q                     <= {rx_sync_q[1:0], serial_in_i};
            if (rx_sync_q[1] == rx_sync_q[2]) begin
                rx_level_q <= rx_sync_q[2];
            end
            tx_irq_q      <= tx_irq_w;
            timeout_irq_q <= char_timeout_i && snoop_raw_w && rx_en_w; // [RL14]
            rx_enable_q   <= rx_en_w;
            rdata_q       <= (read_i && afr_sel_w) ? alternate_function_register_q : 8'h00;
        end
    end

    // receiver sees idle high while disabled
    assign serial_in_o               = rx_level_q | ~rx_enable_q;
    assign rx_enable_o               = rx_enable_q;
    assign tx_irq_o                  = tx_irq_q;
    assign timeout_irq_o             = timeout_irq_q;
    assign rdata_o                   = rdata_q;
    assign infrared_mode_enable_o    = ir_w; // [RL4]
    assign concurrent_write_enable_o = concurrent_write_enable_w;
endmodule : uafc_ctrl

// *** rtl/uafc_turnaround.sv ***
// uafc_turnaround: driver-enable sequencing for one channel in half-duplex bus mode.
// assumes tx_busy_i and tx_write_i come from logic on the same clock.
`timescale 1ns/10ps
module uafc_turnaround #(
    parameter int DLY_W = 3
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    // control
    input  wire logic             enable_i,
    input  wire logic [DLY_W-1:0] delay_i,
    input  wire logic             bit_tick_i,
    // transmitter state
    input  wire logic             tx_busy_i,
    input  wire logic             tx_write_i,
    // output
    output logic                  driver_enable_o
);
    uafc_pkg::uafc_drv_e state_q;
    uafc_pkg::uafc_drv_e state_d;
    logic [DLY_W-1:0]    count_q;
    logic [DLY_W-1:0]    count_d;
    logic                drive_d;
    wire                 done_w = (count_q == '0) || (bit_tick_i && count_q == DLY_W'(1));

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            uafc_pkg::UAFC_IDLE: begin
                if (enable_i && (tx_busy_i || tx_write_i)) begin
                    state_d = uafc_pkg::UAFC_SEND; // [RL5]
                end
            end
            uafc_pkg::UAFC_SEND: begin
                if (!enable_i) begin
                    state_d = uafc_pkg::UAFC_IDLE;
                end else if (!tx_busy_i && !tx_write_i) begin
                    state_d = uafc_pkg::UAFC_HOLD; // [RL15]
                    count_d = delay_i;
                end
            end
            uafc_pkg::UAFC_HOLD: begin
                if (!enable_i) begin
                    state_d = uafc_pkg::UAFC_IDLE;
                end else if (tx_busy_i || tx_write_i) begin
                    state_d = uafc_pkg::UAFC_SEND; // [RL15]
                end else if (done_w) begin
                    state_d = uafc_pkg::UAFC_IDLE; // [RL6]
                    count_d = '0;
                end else if (bit_tick_i) begin
                    count_d = count_q - DLY_W'(1);
                end
            end
            default: begin
                state_d = uafc_pkg::UAFC_IDLE;
            end
        endcase
    end

    assign drive_d = (state_d != uafc_pkg::UAFC_IDLE);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q         <= uafc_pkg::UAFC_IDLE;
            count_q         <= '0;
            driver_enable_o <= 1'b0;
        end else begin
            state_q         <= state_d;
            count_q         <= count_d;
            driver_enable_o <= drive_d; // [RL5] [RL6]
        end
    end
endmodule : uafc_turnaround

// *** shared/uafc_pkg.sv ***
// uafc_pkg: register offsets, field positions, reset values and timing counts
// for the per-channel alternate-function control block.
// assumes the host bus is the documented 3-bit address with a line control page select.
package uafc_pkg;
    localparam logic [2:0] ALT_FUNC_ADDR     = 3'h2;
    localparam logic [2:0] LINE_CTRL_PAGE    = 3'h4;
    localparam int         CONCURRENT_WRITE_ENABLE_BIT          = 0;
    localparam int         IR_BIT            = 1;
    localparam int         HDX_BIT           = 2;
    localparam int         LARGE_BIT         = 3;
    localparam int         SNOOP_BIT         = 4;
    localparam int         DLY_LSB           = 5;
    localparam int         DLY_W             = 3;
    localparam logic [7:0] ALT_FUNC_RESET    = 8'h00;
    localparam int         BIT_TIME_DIV_DEF  = 16;
    localparam int         CHANNELS          = 2;
    typedef enum logic [1:0] {
        UAFC_IDLE,
        UAFC_SEND,
        UAFC_HOLD
    } uafc_drv_e;
endpackage : uafc_pkg

// *** tb/uafc_ctrl_bench.sv ***
// uafc_ctrl_bench: directed scenarios for the alternate-function control block.
// assumes uafc_ctrl, uafc_ctrl_sva and uafc_line_model are compiled before it.
`timescale 1ns/10ps
module uafc_ctrl_bench;
    logic       clock_i = 1'b0, reset_n_i = 1'b0, write_i = 1'b0, read_i = 1'b0;
    logic       tx_fifo_empty_i = 1'b1, tx_shift_empty_i = 1'b1, tx_fifo_below_thr_i = 1'b1;
    logic       tx_write_i = 1'b0, bit_tick_i = 1'b0, char_timeout_i = 1'b1, drive = 1'b1;
    logic       serial_in_i, serial_in_o, rx_enable_o, tx_irq_o, timeout_irq_o, sel_o;
    logic       bus_driver_enable_output_o, infrared_mode_enable_o, concurrent_write_enable_o;
    logic [2:0] addr_i = 3'h2;
    logic [7:0] wdata_i = 8'h00, line_control_register_i = 8'h80, rdata_o;
    logic [1:0] channel_select_i = 2'h1, channel_write_o;
    int         mismatches = 0, total_checks = 0;
    always #2 clock_i = ~clock_i;
    uafc_ctrl u_uafc_ctrl (.clock_i, .reset_n_i, .addr_i, .wdata_i, .write_i, .read_i,
        .line_control_register_i, .rdata_o, .sel_o, .channel_write_o, .channel_select_i,
        .tx_fifo_empty_i, .tx_shift_empty_i, .tx_fifo_below_thr_i, .tx_write_i, .bit_tick_i,
        .serial_in_i, .char_timeout_i, .serial_in_o, .rx_enable_o, .tx_irq_o, .timeout_irq_o,
        .bus_driver_enable_output_o, .infrared_mode_enable_o, .concurrent_write_enable_o);
    uafc_line_model u_uafc_line_model (.clock_i, .drive_i(drive), .line_o(serial_in_i));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(negedge clock_i);
        addr_i = a;
        wdata_i = d;
        write_i = 1'b1;
        @(negedge clock_i);
        write_i = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(output logic [7:0] v);
        @(negedge clock_i);
        addr_i = 3'h2;
        read_i = 1'b1;
        @(negedge clock_i);
        read_i = 1'b0;
        v = rdata_o;
    endtask : rd_reg
    task automatic send;
        @(negedge clock_i);
        tx_write_i = 1'b1;
        tx_shift_empty_i = 1'b0;
        @(negedge clock_i);
        tx_write_i = 1'b0;
        repeat (3) @(negedge clock_i);
    endtask : send
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clock_i);
            bit_tick_i = 1'b1;
            @(negedge clock_i);
            bit_tick_i = 1'b0;
        end
    endtask : ticks
    task automatic t_reset_page;
        logic [7:0] v;
        check(8'({bus_driver_enable_output_o, tx_irq_o, timeout_irq_o, rx_enable_o}),
            8'h01);
        line_control_register_i = 8'h00;
        wr_reg(3'h2, 8'hff);
        line_control_register_i = 8'h80;
        wr_reg(3'h3, 8'hff);
        rd_reg(v);
        check(v, 8'h00);
        wr_reg(3'h2, 8'h01);
        @(negedge clock_i);
        addr_i = 3'h0;
        write_i = 1'b1;
        #1 check(8'(channel_write_o), 8'h03);
        wr_reg(3'h2, 8'h00);
    endtask : t_reset_page
    task automatic t_turnaround;
        wr_reg(3'h2, 8'he4);
        send;
        check(8'(tx_irq_o), 8'h00);
        tx_shift_empty_i = 1'b1;
        ticks(2);
        send;
        tx_shift_empty_i = 1'b1;
        ticks(6);
        check(8'({bus_driver_enable_output_o, tx_irq_o}), 8'h03);
        ticks(1);
        check(8'(bus_driver_enable_output_o), 8'h00);
        wr_reg(3'h2, 8'h0c);
        tx_fifo_empty_i = 1'b0;
        send;
        check(8'(tx_irq_o), 8'h01);
        tx_fifo_below_thr_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check(8'(tx_irq_o), 8'h00);
        tx_fifo_below_thr_i = 1'b1;
        tx_fifo_empty_i = 1'b1;
        tx_shift_empty_i = 1'b1;
        ticks(1);
    endtask : t_turnaround
    task automatic t_modes;
        logic [7:0] alternate_function_control [6] = '{8'h34, 8'h02, 8'h10, 8'h00, 8'h04, 8'h12};
        logic [3:0] exp [6] = '{4'hf, 4'h0, 4'h7, 4'h6, 4'h8, 4'h7};
        int         lows;
        for (int i = 0; i < 6; i++) begin
            wr_reg(3'h2, alternate_function_control[i]);
            send;
            lows = 0;
            repeat (16) @(negedge clock_i) lows += (serial_in_o === 1'b0);
            check(8'({bus_driver_enable_output_o, rx_enable_o, lows != 0, timeout_irq_o}),
                8'(exp[i]));
            tx_shift_empty_i = 1'b1;
            ticks(2);
        end
    endtask : t_modes
    task automatic t_rerun;
        logic [7:0] v;
        wr_reg(3'h2, 8'hff);
        @(negedge clock_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        reset_n_i = 1'b1;
        check(8'({infrared_mode_enable_o, concurrent_write_enable_o,
            bus_driver_enable_output_o}), 8'h00);
        rd_reg(v);
        check(v, 8'h00);
    endtask : t_rerun
    task automatic final_report;
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(negedge clock_i);
        reset_n_i = 1'b1;
        t_reset_page;
        t_turnaround;
        t_modes;
        t_rerun;
        final_report;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        mismatches++;
        final_report;
    end
endmodule : uafc_ctrl_bench

// *** tb/uafc_ctrl_sva.sv ***
// uafc_ctrl_sva: port-level checks of the alternate-function control block.
// assumes one clock domain and binding onto every uafc_ctrl instance.
`timescale 1ns/10ps
module uafc_ctrl_sva #(
    parameter int CHANNELS = 2
) (
    input wire logic                clock_i,
    input wire logic                reset_n_i,
    input wire logic [2:0]          addr_i,
    input wire logic [7:0]          wdata_i,
    input wire logic                write_i,
    input wire logic                read_i,
    input wire logic [7:0]          line_control_register_i,
    input wire logic [7:0]          rdata_o,
    input wire logic                sel_o,
    input wire logic [CHANNELS-1:0] channel_write_o,
    input wire logic [CHANNELS-1:0] channel_select_i,
    input wire logic                tx_fifo_empty_i,
    input wire logic                tx_shift_empty_i,
    input wire logic                tx_write_i,
    input wire logic                char_timeout_i,
    input wire logic                timeout_irq_o,
    input wire logic                bus_driver_enable_output_o,
    input wire logic                infrared_mode_enable_o,
    input wire logic                concurrent_write_enable_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_reg_wr; write_i && sel_o; endsequence
    sequence s_busy; !tx_fifo_empty_i || !tx_shift_empty_i || tx_write_i; endsequence
    property p_sel; sel_o == (addr_i == uafc_pkg::ALT_FUNC_ADDR
        && line_control_register_i[7:5] == 3'h4); endproperty
    property p_chw; channel_write_o == ({CHANNELS{write_i}}
        & ({CHANNELS{concurrent_write_enable_o}} | channel_select_i)); endproperty
    property p_wr; s_reg_wr |=> {infrared_mode_enable_o, concurrent_write_enable_o}
        == $past(wdata_i[1:0]); endproperty
    property p_rd; read_i && sel_o && !write_i |=> rdata_o[1:0]
        == {infrared_mode_enable_o, concurrent_write_enable_o}; endproperty
    property p_rd0; !(read_i && sel_o) |=> rdata_o == 8'h00; endproperty
    property p_tmo; timeout_irq_o |-> $past(char_timeout_i); endproperty
    property p_rise; $rose(bus_driver_enable_output_o) |-> $past(tx_write_i)
        || !$past(tx_fifo_empty_i) || !$past(tx_shift_empty_i); endproperty
    property p_hold; bus_driver_enable_output_o ##0 s_busy ##0 !write_i
        |=> bus_driver_enable_output_o; endproperty
    property p_fall; $fell(bus_driver_enable_output_o) |-> $past(tx_fifo_empty_i)
        && $past(tx_shift_empty_i) && !$past(tx_write_i); endproperty
    a_sel: assert property (p_sel) else $error("select decode wrong");
    a_chw: assert property (p_chw) else $error("channel write fan-out wrong");
    a_wr: assert property (p_wr) else $error("mode bits not written");
    a_rd: assert property (p_rd) else $error("read data wrong");
    a_rd0: assert property (p_rd0) else $error("read data not idle");
    a_tmo: assert property (p_tmo) else $error("timeout without cause");
    a_rise: assert property (p_rise) else $error("driver enable rose idle");
    a_hold: assert property (p_hold) else $error("driver enable dropped busy");
    a_fall: assert property (p_fall) else $error("driver enable fell early");
endmodule : uafc_ctrl_sva
bind uafc_ctrl uafc_ctrl_sva #(.CHANNELS(CHANNELS)) u_uafc_ctrl_sva (.clock_i, .reset_n_i,
    .addr_i, .wdata_i, .write_i, .read_i, .line_control_register_i, .rdata_o, .sel_o,
    .channel_write_o, .channel_select_i, .tx_fifo_empty_i, .tx_shift_empty_i, .tx_write_i,
    .char_timeout_i, .timeout_irq_o, .bus_driver_enable_output_o, .infrared_mode_enable_o,
    .concurrent_write_enable_o);

// *** tb/uafc_line_model.sv ***
// uafc_line_model: serial line seen by the receiver (transceiver or optics echo).
// assumes a released line idles high through its pull-up.
`timescale 1ns/10ps
module uafc_line_model (
    input  wire logic clock_i,
    input  wire logic drive_i,
    output logic      line_o
);
    logic [2:0] cnt_q = 3'h0;
    always @(posedge clock_i) cnt_q <= cnt_q + 3'h1;
    assign line_o = drive_i ? cnt_q[2] : 1'b1;
endmodule : uafc_line_model
